// File: hdl/cta_map.svh
// Named constants of the datapath
`ifndef CTA_MAP_SVH
`define CTA_MAP_SVH
// Condition code bit positions
`define CTA_FLAG_C 0
`define CTA_FLAG_V 1
`define CTA_FLAG_Z 2
`define CTA_FLAG_N 3
`define CTA_FLAG_H 4
`define CTA_CCR_RESET 5'h00
// Register file shape and byte-half select bit
`define CTA_NUM_REGS 8
`define CTA_HALF_BIT 3
`define CTA_STACK_REG 3'h7
`define CTA_REG_RESET 16'h0000
// Sign bits and half-carry taps per operand size
`define CTA_BYTE_MSB 7
`define CTA_WORD_MSB 15
`define CTA_BYTE_HBIT 4
`define CTA_WORD_HBIT 12
// Pointer steps and address-adjust constants
`define CTA_STEP_ONE 16'h0001
`define CTA_STEP_TWO 16'h0002
// Page of short absolute addresses
`define CTA_ABS8_PAGE 8'hFF
// Decimal correction
`define CTA_BCD_LO 8'h06
`define CTA_BCD_HI 8'h60
`define CTA_BCD_MAX 8'h99
`define CTA_BCD_DIGIT 4'h9
`endif

// File: hdl/cta_pkg.sv
// Types and shared helpers of the datapath
`include "cta_map.svh"
package cta_pkg;
  // Command operation
  typedef enum logic [4:0] {
    OP_MOVE = 5'h00, OP_PUSH = 5'h01, OP_POP = 5'h02, OP_ADD = 5'h03,
    OP_SUB = 5'h04, OP_ADD_CARRY = 5'h05, OP_SUB_BORROW = 5'h06, OP_INC = 5'h07,
    OP_DECREMENT = 5'h08, OP_ADDR_ADD = 5'h09, OP_ADDR_SUB = 5'h0A, OP_BCD_ADD = 5'h0B,
    OP_BCD_SUB = 5'h0C, OP_UMUL = 5'h0D, OP_UDIV = 5'h0E, OP_COMPARE = 5'h0F,
    OP_NEGATE = 5'h10, OP_AND = 5'h11, OP_OR = 5'h12, OP_XOR = 5'h13, OP_NOT = 5'h14
  } cta_op_t;
  // Operand addressing mode
  typedef enum logic [2:0] {
    MD_REG = 3'h0, MD_IND = 3'h1, MD_DISP = 3'h2, MD_ABS16 = 3'h3,
    MD_ABS8 = 3'h4, MD_IMM = 3'h5, MD_PREDEC = 3'h6, MD_POSTINC = 3'h7
  } cta_mode_t;
  // Sequencer states, one-hot
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_MEM = 2'b10
  } cta_state_t;

  // Read a register as a word or a byte half
  function automatic logic [15:0] rd_half(input logic [15:0] w, input logic [3:0] idx,
                                          input logic word);
    if (word) begin
      return w;
    end
    return {8'h00, idx[`CTA_HALF_BIT] ? w[7:0] : w[15:8]};
  endfunction

  // Merge a result into the addressed half only
  function automatic logic [15:0] wr_half(input logic [15:0] old, input logic [15:0] nv,
                                          input logic [3:0] idx, input logic word);
    if (word) begin
      return nv;
    end
    return idx[`CTA_HALF_BIT] ? {old[15:8], nv[7:0]} : {nv[7:0], old[7:0]};
  endfunction

  // Sign of a value at the operand size
  function automatic logic sign_of(input logic [15:0] v, input logic word);
    return word ? v[`CTA_WORD_MSB] : v[`CTA_BYTE_MSB];
  endfunction

  // Zero test at the operand size
  function automatic logic is_zero(input logic [15:0] v, input logic word);
    return word ? (v == 16'h0000) : (v[7:0] == 8'h00);
  endfunction
endpackage

// File: hdl/cta_alu.sv
// Combinational ALU with flag generation
`timescale 1ns/1ns
`include "cta_map.svh"
module cta_alu (
  input wire cta_pkg::cta_op_t op,
  input wire logic word,
  input wire logic [15:0] a,
  input wire logic [15:0] b,
  input wire logic [4:0] flags_i,
  output logic [15:0] res,
  output logic [4:0] flags_o,
  output logic flags_we
);
  logic cin;
  logic is_sub;
  logic [16:0] sum;
  logic [15:0] hx;
  logic sa;
  logic sb;
  logic sr;
  logic [7:0] adj;
  logic bcd_c;
  logic [15:0] quo;
  logic [15:0] rem;

  // Carry or borrow enters only the carry-inclusive forms
  assign cin = ((op == cta_pkg::OP_ADD_CARRY) || (op == cta_pkg::OP_SUB_BORROW))
               & flags_i[`CTA_FLAG_C];
  assign is_sub = op inside {cta_pkg::OP_SUB, cta_pkg::OP_SUB_BORROW, cta_pkg::OP_DECREMENT,
                             cta_pkg::OP_ADDR_SUB, cta_pkg::OP_COMPARE, cta_pkg::OP_NEGATE};
  // Byte operands arrive zero-extended, so bit 8 is the byte carry or borrow
  assign sum = is_sub ? ({1'b0, a} - {1'b0, b} - {16'h0000, cin})
                      : ({1'b0, a} + {1'b0, b} + {16'h0000, cin});
  assign hx = a ^ b ^ sum[15:0];
  assign sa = cta_pkg::sign_of(a, word);
  assign sb = cta_pkg::sign_of(b, word);
  assign sr = cta_pkg::sign_of(sum[15:0], word);
  // A zero divisor is caught where the result is picked
  assign quo = a / {8'h00, b[7:0]};
  assign rem = a % {8'h00, b[7:0]};

  // Decimal correction from carry, half-carry and digits
  always_comb begin
    adj = 8'h00;
    bcd_c = flags_i[`CTA_FLAG_C];
    if (op == cta_pkg::OP_BCD_ADD) begin
      if (flags_i[`CTA_FLAG_C] || (a[7:0] > `CTA_BCD_MAX)) begin
        adj = `CTA_BCD_HI;
        bcd_c = 1'b1;
      end
      if (flags_i[`CTA_FLAG_H] || (a[3:0] > `CTA_BCD_DIGIT)) begin
        adj = adj | `CTA_BCD_LO;
      end
    end else begin
      if (flags_i[`CTA_FLAG_C]) begin
        adj = `CTA_BCD_HI;
      end
      if (flags_i[`CTA_FLAG_H]) begin
        adj = adj | `CTA_BCD_LO;
      end
    end
  end

  // Result and flags per operation
  always_comb begin
    res = b;
    flags_o = flags_i;
    flags_we = 1'b1;
    case (op)
      cta_pkg::OP_ADD, cta_pkg::OP_SUB, cta_pkg::OP_ADD_CARRY, cta_pkg::OP_SUB_BORROW,
      cta_pkg::OP_COMPARE, cta_pkg::OP_NEGATE, cta_pkg::OP_INC, cta_pkg::OP_DECREMENT: begin
        res = sum[15:0];
        flags_o[`CTA_FLAG_N] = sr;
        flags_o[`CTA_FLAG_Z] = cta_pkg::is_zero(sum[15:0], word);
        flags_o[`CTA_FLAG_V] = (sr != sa) && ((sa != sb) == is_sub);
        // Increment and decrement keep carry so multi-byte loops stay intact
        if ((op != cta_pkg::OP_INC) && (op != cta_pkg::OP_DECREMENT)) begin
          flags_o[`CTA_FLAG_C] = word ? sum[16] : sum[8];
          flags_o[`CTA_FLAG_H] = word ? hx[`CTA_WORD_HBIT] : hx[`CTA_BYTE_HBIT];
        end
      end
      cta_pkg::OP_ADDR_ADD, cta_pkg::OP_ADDR_SUB: begin
        res = sum[15:0];
        flags_we = 1'b0;
      end
      cta_pkg::OP_BCD_ADD, cta_pkg::OP_BCD_SUB: begin
        res = {8'h00, (op == cta_pkg::OP_BCD_ADD) ? a[7:0] + adj : a[7:0] - adj};
        flags_o[`CTA_FLAG_N] = cta_pkg::sign_of(res, 1'b0);
        flags_o[`CTA_FLAG_Z] = cta_pkg::is_zero(res, 1'b0);
        flags_o[`CTA_FLAG_C] = bcd_c;
      end
      cta_pkg::OP_UMUL: begin
        res = 16'({8'h00, a[7:0]} * {8'h00, b[7:0]});
        flags_we = 1'b0;
      end
      cta_pkg::OP_UDIV: begin
        res = (b[7:0] == 8'h00) ? a : {rem[7:0], quo[7:0]};
        flags_o[`CTA_FLAG_N] = b[`CTA_BYTE_MSB];
        flags_o[`CTA_FLAG_Z] = (b[7:0] == 8'h00);
      end
      cta_pkg::OP_AND, cta_pkg::OP_OR, cta_pkg::OP_XOR, cta_pkg::OP_NOT: begin
        case (op)
          cta_pkg::OP_AND: res = a & b;
          cta_pkg::OP_OR: res = a | b;
          cta_pkg::OP_XOR: res = a ^ b;
          default: res = ~a;
        endcase
        flags_o[`CTA_FLAG_N] = cta_pkg::sign_of(res, word);
        flags_o[`CTA_FLAG_Z] = cta_pkg::is_zero(res, word);
        flags_o[`CTA_FLAG_V] = 1'b0;
      end
      default: begin
        flags_o[`CTA_FLAG_N] = cta_pkg::sign_of(b, word);
        flags_o[`CTA_FLAG_Z] = cta_pkg::is_zero(b, word);
        flags_o[`CTA_FLAG_V] = 1'b0;
      end
    endcase
  end
endmodule

// File: hdl/cta_exec.sv
// Execution datapath: transfer, arithmetic and logic
`timescale 1ns/1ns
`include "cta_map.svh"
// How it works
// - Move byte or word among registers, memory, immediate
// - Word moves accept all seven listed modes
// - Short absolute mode allowed for byte moves
// - Pop reads word at stack, then advances
// - Push lowers stack pointer, then stores word
// - Add or subtract registers; immediate only for add
// - Word add and subtract only between registers
// - Carry-inclusive add and subtract are byte only
// - Increment or decrement a byte by one
// - Address adjust adds or subtracts one or two
// - Decimal adjust corrects byte using condition flags
// - Byte times byte gives full word product
// - Word divided by byte: quotient and remainder
// - Compare subtracts, updates flags, keeps registers
// - Word compare only between two registers
// - Negate replaces byte with zero minus it
// - Bitwise and with register or immediate
// - Bitwise or with register or immediate
// - Bitwise exclusive or with register or immediate
// - Complement inverts every bit of a byte register
// - Pre-decrement lowers pointer by size, keeps it
// - Odd word address accesses the preceding even word
// - Flags negative, zero, overflow, carry follow results
module cta_exec (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic op_valid,
  output logic op_ready,
  input wire cta_pkg::cta_op_t op_code,
  input wire logic op_word,
  input wire cta_pkg::cta_mode_t op_mode,
  input wire logic op_store,
  input wire logic [3:0] op_dst,
  input wire logic [3:0] op_src,
  input wire logic [2:0] op_ptr,
  input wire logic [15:0] op_imm,
  output logic op_done,
  output logic op_illegal,
  output logic mem_req,
  output logic mem_we,
  output logic mem_byte,
  output logic [15:0] mem_addr,
  output logic [15:0] mem_wdata,
  input wire logic [15:0] mem_rdata,
  input wire logic mem_ack,
  output logic [4:0] cond_code,
  input wire logic [2:0] peek_idx,
  output logic [15:0] peek_data
);
  // ********************************************************************
  // Storage
  // ********************************************************************
  logic [15:0] regs_q [0:`CTA_NUM_REGS-1];
  logic [4:0] ccr_q;
  cta_pkg::cta_state_t state_q;
  logic [15:0] addr_q;
  logic [15:0] wdata_q;
  logic we_q;
  logic byte_q;
  logic [3:0] pend_idx_q;
  logic done_q;
  logic illegal_q;
  logic [15:0] peek_q;

  // ********************************************************************
  // Decode
  // ********************************************************************
  cta_pkg::cta_mode_t mode;
  logic store;
  logic [2:0] ptr;
  logic [3:0] src_idx;
  logic [3:0] dst_idx;
  logic dst_w;
  logic src_w;
  logic is_mem;
  logic illegal;
  logic byte_only;
  logic issue;
  logic [15:0] alu_a;
  logic [15:0] alu_b;
  logic [15:0] alu_res;
  logic [4:0] alu_flags;
  logic alu_flags_we;
  logic [15:0] base;
  logic [15:0] step;
  logic [15:0] ea;
  logic ptr_we;
  logic [15:0] ptr_val;
  logic wr_en;
  logic [15:0] st_data;
  logic ack_load;
  logic [15:0] ld_data;

  // Stack operations are word moves through register 7
  always_comb begin
    mode = op_mode;
    store = op_store;
    ptr = op_ptr;
    src_idx = op_src;
    dst_idx = op_dst;
    if (op_code == cta_pkg::OP_PUSH) begin
      mode = cta_pkg::MD_PREDEC;
      store = 1'b1;
      ptr = `CTA_STACK_REG;
    end else if (op_code == cta_pkg::OP_POP) begin
      mode = cta_pkg::MD_POSTINC;
      store = 1'b0;
      ptr = `CTA_STACK_REG;
    end
  end

  // Operand width: some operations have a fixed size
  always_comb begin
    case (op_code)
      cta_pkg::OP_PUSH, cta_pkg::OP_POP, cta_pkg::OP_ADDR_ADD, cta_pkg::OP_ADDR_SUB,
      cta_pkg::OP_UMUL, cta_pkg::OP_UDIV: dst_w = 1'b1;
      cta_pkg::OP_MOVE, cta_pkg::OP_ADD, cta_pkg::OP_SUB, cta_pkg::OP_COMPARE: dst_w = op_word;
      default: dst_w = 1'b0;
    endcase
    // Multiply and divide read a byte source
    src_w = dst_w && (op_code != cta_pkg::OP_UMUL) && (op_code != cta_pkg::OP_UDIV);
    byte_only = op_code inside {cta_pkg::OP_ADD_CARRY, cta_pkg::OP_SUB_BORROW,
                                cta_pkg::OP_INC, cta_pkg::OP_DECREMENT, cta_pkg::OP_BCD_ADD,
                                cta_pkg::OP_BCD_SUB, cta_pkg::OP_NEGATE, cta_pkg::OP_AND,
                                cta_pkg::OP_OR, cta_pkg::OP_XOR, cta_pkg::OP_NOT};
  end

  // Memory operand and refused forms
  always_comb begin
    is_mem = ((op_code == cta_pkg::OP_MOVE) || (op_code == cta_pkg::OP_PUSH) ||
              (op_code == cta_pkg::OP_POP)) &&
             (mode != cta_pkg::MD_REG) && (mode != cta_pkg::MD_IMM);
    illegal = 1'b0;
    if ((op_code == cta_pkg::OP_MOVE) && op_word && (mode == cta_pkg::MD_ABS8)) begin
      illegal = 1'b1;
    end else if ((op_code == cta_pkg::OP_MOVE) && store && (mode == cta_pkg::MD_IMM)) begin
      illegal = 1'b1;
    end else if ((op_code == cta_pkg::OP_SUB) && (mode == cta_pkg::MD_IMM)) begin
      illegal = 1'b1;
    end else if ((op_code == cta_pkg::OP_ADD) && op_word && (mode == cta_pkg::MD_IMM)) begin
      illegal = 1'b1;
    end else if ((op_code == cta_pkg::OP_COMPARE) && op_word && (mode == cta_pkg::MD_IMM)) begin
      illegal = 1'b1;
    end else if (byte_only && op_word) begin
      illegal = 1'b1;
    end else if (!is_mem && (mode != cta_pkg::MD_REG) && (mode != cta_pkg::MD_IMM) &&
                 (op_code != cta_pkg::OP_PUSH) && (op_code != cta_pkg::OP_POP)) begin
      illegal = 1'b1;
    end else if (op_code > cta_pkg::OP_NOT) begin
      illegal = 1'b1;
    end
  end

  // ********************************************************************
  // Operand selection
  // ********************************************************************
  // Immediate data serves the immediate forms and picks the address-adjust step
  always_comb begin
    alu_a = cta_pkg::rd_half(regs_q[dst_idx[2:0]], dst_idx, dst_w);
    if (mode == cta_pkg::MD_IMM) begin
      alu_b = dst_w ? op_imm : {8'h00, op_imm[7:0]};
    end else begin
      alu_b = cta_pkg::rd_half(regs_q[src_idx[2:0]], src_idx, src_w);
    end
    case (op_code)
      cta_pkg::OP_INC, cta_pkg::OP_DECREMENT: alu_b = `CTA_STEP_ONE;
      cta_pkg::OP_ADDR_ADD, cta_pkg::OP_ADDR_SUB: begin
        alu_b = op_imm[1] ? `CTA_STEP_TWO : `CTA_STEP_ONE;
      end
      cta_pkg::OP_NEGATE: begin
        alu_a = 16'h0000;
        alu_b = cta_pkg::rd_half(regs_q[dst_idx[2:0]], dst_idx, 1'b0);
      end
      default: alu_b = alu_b;
    endcase
  end

  cta_alu u_alu (
    .op(op_code),
    .word(dst_w),
    .a(alu_a),
    .b(alu_b),
    .flags_i(ccr_q),
    .res(alu_res),
    .flags_o(alu_flags),
    .flags_we(alu_flags_we)
  );

  // ********************************************************************
  // Effective address
  // ********************************************************************
  // Pointer moves by the operand size; the reduced value is the address
  always_comb begin
    base = regs_q[ptr];
    step = dst_w ? `CTA_STEP_TWO : `CTA_STEP_ONE;
    ptr_we = 1'b0;
    ptr_val = base;
    case (mode)
      cta_pkg::MD_DISP: ea = base + op_imm;
      cta_pkg::MD_ABS16: ea = op_imm;
      cta_pkg::MD_ABS8: ea = {`CTA_ABS8_PAGE, op_imm[7:0]};
      cta_pkg::MD_PREDEC: begin
        ea = base - step;
        ptr_we = 1'b1;
        ptr_val = base - step;
      end
      cta_pkg::MD_POSTINC: begin
        ea = base;
        ptr_we = 1'b1;
        ptr_val = base + step;
      end
      default: ea = base;
    endcase
    // Word accesses never straddle: the low address bit is dropped
    if (dst_w) begin
      ea[0] = 1'b0;
    end
    st_data = cta_pkg::rd_half(regs_q[src_idx[2:0]], src_idx, dst_w);
  end

  // ********************************************************************
  // Sequencing
  // ********************************************************************
  assign op_ready = (state_q == cta_pkg::ST_IDLE);
  assign issue = op_valid && op_ready && !illegal;
  // Compare and memory moves write no result register at issue
  assign wr_en = issue && !is_mem && (op_code != cta_pkg::OP_COMPARE);
  assign ack_load = (state_q == cta_pkg::ST_MEM) && mem_ack && !we_q;
  assign ld_data = byte_q ? {8'h00, mem_rdata[7:0]} : mem_rdata;

  // Memory operations hold the bus until acknowledged
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      state_q <= cta_pkg::ST_IDLE;
    end else begin
      case (state_q)
        cta_pkg::ST_IDLE: begin
          if (issue && is_mem) begin
            state_q <= cta_pkg::ST_MEM;
          end
        end
        cta_pkg::ST_MEM: begin
          if (mem_ack) begin
            state_q <= cta_pkg::ST_IDLE;
          end
        end
        default: state_q <= cta_pkg::ST_IDLE;
      endcase
    end
  end

  // Bus request fields, captured at issue
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      addr_q <= 16'h0000;
      wdata_q <= 16'h0000;
      we_q <= 1'b0;
      byte_q <= 1'b0;
      pend_idx_q <= 4'h0;
    end else if (issue && is_mem) begin
      addr_q <= ea;
      wdata_q <= st_data;
      we_q <= store;
      byte_q <= !dst_w;
      pend_idx_q <= dst_idx;
    end
  end

  // Register file: pointer update and results at issue, loaded data at ack
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      for (int i = 0; i < `CTA_NUM_REGS; i++) begin
        regs_q[i] <= `CTA_REG_RESET;
      end
    end else begin
      if (issue && is_mem && ptr_we) begin
        regs_q[ptr] <= ptr_val;
      end
      if (wr_en) begin
        regs_q[dst_idx[2:0]] <= cta_pkg::wr_half(regs_q[dst_idx[2:0]], alu_res, dst_idx,
                                                 dst_w);
      end
      if (ack_load) begin
        regs_q[pend_idx_q[2:0]] <= cta_pkg::wr_half(regs_q[pend_idx_q[2:0]], ld_data,
                                                    pend_idx_q, !byte_q);
      end
    end
  end

  // Flags follow ALU results and finished memory moves
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      ccr_q <= `CTA_CCR_RESET;
    end else if (issue && !is_mem && alu_flags_we) begin
      ccr_q <= alu_flags;
    end else if ((state_q == cta_pkg::ST_MEM) && mem_ack) begin
      ccr_q[`CTA_FLAG_N] <= cta_pkg::sign_of(we_q ? wdata_q : ld_data, !byte_q);
      ccr_q[`CTA_FLAG_Z] <= cta_pkg::is_zero(we_q ? wdata_q : ld_data, !byte_q);
      ccr_q[`CTA_FLAG_V] <= 1'b0;
    end
  end

  // Completion and refusal pulses, one cycle each
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      done_q <= 1'b0;
      illegal_q <= 1'b0;
    end else begin
      done_q <= (issue && !is_mem) || ((state_q == cta_pkg::ST_MEM) && mem_ack);
      illegal_q <= op_valid && op_ready && illegal;
    end
  end

  // Peek port, one cycle behind the index
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      peek_q <= `CTA_REG_RESET;
    end else begin
      peek_q <= regs_q[peek_idx];
    end
  end

  // ********************************************************************
  // Outputs
  // ********************************************************************
  assign mem_req = (state_q == cta_pkg::ST_MEM);
  assign mem_we = we_q;
  assign mem_byte = byte_q;
  assign mem_addr = addr_q;
  // Byte stores travel in the low lane
  assign mem_wdata = wdata_q;
  assign op_done = done_q;
  assign op_illegal = illegal_q;
  assign cond_code = ccr_q;
  assign peek_data = peek_q;
endmodule

// File: bench/cta_exec_sva.sv
// Port checks of the execution datapath
`timescale 1ns/1ns
module cta_exec_sva (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic op_valid,
  input wire logic op_ready,
  input wire cta_pkg::cta_op_t op_code,
  input wire logic op_word,
  input wire cta_pkg::cta_mode_t op_mode,
  input wire logic [15:0] op_imm,
  input wire logic op_done,
  input wire logic op_illegal,
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic mem_byte,
  input wire logic [15:0] mem_addr,
  input wire logic mem_ack
);
  logic tk;
  // Command taken at this edge
  assign tk = op_valid && op_ready;
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (sys_rst);
  property p_push;
    tk && op_code == cta_pkg::OP_PUSH |=> mem_req && mem_we && !mem_byte;
  endproperty
  a_push: assert property (p_push) else $error("push gave no word write");
  property p_pop;
    tk && op_code == cta_pkg::OP_POP |=> mem_req && !mem_we && !mem_byte;
  endproperty
  a_pop: assert property (p_pop) else $error("pop gave no word read");
  property p_abs8;
    tk && op_code == cta_pkg::OP_MOVE && !op_word && op_mode == cta_pkg::MD_ABS8
      |=> mem_addr == {8'hFF, $past(op_imm[7:0])};
  endproperty
  a_abs8: assert property (p_abs8) else $error("short address not in top page");
  property p_imm_ref;
    tk && op_mode == cta_pkg::MD_IMM && (op_code == cta_pkg::OP_SUB || (op_word &&
      (op_code == cta_pkg::OP_ADD || op_code == cta_pkg::OP_COMPARE))) |=> op_illegal && !op_done;
  endproperty
  a_imm_ref: assert property (p_imm_ref) else $error("immediate form taken");
  property p_w8;
    tk && op_code == cta_pkg::OP_MOVE && op_word && op_mode == cta_pkg::MD_ABS8 |=> op_illegal;
  endproperty
  a_w8: assert property (p_w8) else $error("word short-address move taken");
  property p_even;
    mem_req && !mem_byte |-> !mem_addr[0];
  endproperty
  a_even: assert property (p_even) else $error("odd word address");
  property p_hold;
    mem_req && !mem_ack |=> mem_req && $stable(mem_addr) && $stable(mem_we);
  endproperty
  a_hold: assert property (p_hold) else $error("access dropped before ack");
  property p_fin;
    mem_req && mem_ack |=> !mem_req && op_done ##1 !op_done;
  endproperty
  a_fin: assert property (p_fin) else $error("no single done after ack");
endmodule
bind cta_exec cta_exec_sva u_sva (.clock, .sys_rst, .op_valid, .op_ready, .op_code, .op_word,
  .op_mode, .op_imm, .op_done, .op_illegal, .mem_req, .mem_we, .mem_byte, .mem_addr, .mem_ack);

// File: bench/cta_mem_model.sv
// Behavioural memory behind the datapath
`timescale 1ns/1ns
module cta_mem_model (
  input wire logic clock,
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic mem_byte,
  input wire logic [15:0] mem_addr,
  input wire logic [15:0] mem_wdata,
  output logic [15:0] mem_rdata,
  output logic mem_ack
);
  logic [7:0] m [0:65535] = '{default: 8'h00};
  logic ack_q = 1'b0;
  logic slow_q = 1'b0;
  logic [15:0] rd_q = 16'h0000;
  int wait_n = 0;
  assign mem_ack = ack_q;
  assign mem_rdata = rd_q;
  // Prompt and slow answers alternate; data is valid only in the ack cycle
  always @(posedge clock) begin
    if (mem_req && !ack_q && wait_n >= (slow_q ? 3 : 0)) begin
      ack_q <= 1'b1;
      wait_n <= 0;
      slow_q <= !slow_q;
      rd_q <= mem_byte ? {8'h00, m[mem_addr]} : {m[mem_addr], m[mem_addr + 16'h0001]};
      if (mem_we && mem_byte) begin
        m[mem_addr] <= mem_wdata[7:0];
      end else if (mem_we) begin
        m[mem_addr] <= mem_wdata[15:8];
        m[mem_addr + 16'h0001] <= mem_wdata[7:0];
      end
    end else begin
      ack_q <= 1'b0;
      rd_q <= ~rd_q;
      wait_n <= (mem_req && !ack_q) ? wait_n + 1 : 0;
    end
  end
endmodule

// File: bench/cta_exec_test.sv
// Self-checking bench of the execution datapath
`timescale 1ns/1ns
module cta_exec_test;
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  logic op_valid = 1'b0;
  cta_pkg::cta_op_t op_code = cta_pkg::OP_MOVE;
  logic op_word = 1'b0;
  cta_pkg::cta_mode_t op_mode = cta_pkg::MD_REG;
  logic op_store = 1'b0;
  logic [3:0] op_dst = 4'h0;
  logic [3:0] op_src = 4'h0;
  logic [2:0] op_ptr = 3'h0;
  logic [15:0] op_imm = 16'h0000;
  logic [2:0] peek_idx = 3'h0;
  logic op_ready, op_done, op_illegal, mem_req, mem_we, mem_byte, mem_ack, ill;
  logic [15:0] mem_addr, mem_wdata, mem_rdata, peek_data;
  logic [4:0] cond_code;
  int err_total = 0;
  int cmp_count = 0;
  cta_exec uut (.clock, .sys_rst, .op_valid, .op_ready, .op_code, .op_word, .op_mode, .op_store,
    .op_dst, .op_src, .op_ptr, .op_imm, .op_done, .op_illegal, .mem_req, .mem_we, .mem_byte,
    .mem_addr, .mem_wdata, .mem_rdata, .mem_ack, .cond_code, .peek_idx, .peek_data);
  cta_mem_model u_mem (.clock, .mem_req, .mem_we, .mem_byte, .mem_addr, .mem_wdata, .mem_rdata,
    .mem_ack);
  initial forever #5 clock = ~clock;
  // ****
  // Shared tasks
  // ****
  task automatic chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic tally_and_finish();
    $display("compares %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // One command, then a bounded wait for done or refusal
  task automatic run(input cta_pkg::cta_op_t c, input logic w, input cta_pkg::cta_mode_t md,
                     input logic s, input logic [3:0] d, input logic [3:0] r,
                     input logic [2:0] p, input logic [15:0] i);
    int n = 0;
    @(posedge clock);
    op_valid <= 1'b1;
    op_code <= c;
    op_word <= w;
    op_mode <= md;
    op_store <= s;
    op_dst <= d;
    op_src <= r;
    op_ptr <= p;
    op_imm <= i;
    @(posedge clock);
    op_valid <= 1'b0;
    #1;
    while (op_done !== 1'b1 && op_illegal !== 1'b1 && n < 40) begin
      @(posedge clock);
      #1;
      n++;
    end
    ill = op_illegal;
    if (n == 40) begin
      err_total++;
      tally_and_finish();
    end
  endtask
  task automatic mv(input logic [2:0] d, input logic [15:0] i);
    run(cta_pkg::OP_MOVE, 1'b1, cta_pkg::MD_IMM, 1'b0, {1'b0, d}, 4'h0, 3'h0, i);
  endtask
  task automatic alu(input cta_pkg::cta_op_t c, input logic [3:0] d, input logic [3:0] r,
                     input logic [15:0] i);
    run(c, 1'b0, cta_pkg::MD_REG, 1'b0, d, r, 3'h0, i);
  endtask
  // Peek data lags the index by one clock
  task automatic ck(input logic [2:0] x, input logic [15:0] e);
    @(posedge clock);
    peek_idx <= x;
    @(posedge clock);
    #1;
    chk("register", peek_data, e);
  endtask
  // ****
  // Scenarios
  // ****
  task automatic t_alu();
    cta_pkg::cta_op_t ops [10] = '{cta_pkg::OP_ADD, cta_pkg::OP_SUB, cta_pkg::OP_AND,
      cta_pkg::OP_OR, cta_pkg::OP_XOR, cta_pkg::OP_INC, cta_pkg::OP_DECREMENT,
      cta_pkg::OP_NEGATE, cta_pkg::OP_NOT, cta_pkg::OP_COMPARE};
    logic [7:0] res [10] = '{8'h01, 8'h77, 8'h04, 8'hFD, 8'hF9, 8'h3D, 8'h3B, 8'hC4, 8'hC3, 8'h3C};
    foreach (ops[k]) begin
      mv(3'h2, 16'h5A3C);
      mv(3'h3, 16'h00C5);
      alu(ops[k], 4'hA, 4'hB, 16'h0000);
      ck(3'h2, {8'h5A, res[k]});
    end
    chk("flags", {12'h000, cond_code[3:0]}, 16'h0001);
    run(cta_pkg::OP_ADD_CARRY, 1'b0, cta_pkg::MD_IMM, 1'b0, 4'hA, 4'h0, 3'h0, 16'h0010);
    ck(3'h2, 16'h5A4D);
    alu(cta_pkg::OP_SUB_BORROW, 4'hA, 4'hB, 16'h0000);
    ck(3'h2, 16'h5A88);
    chk("flags", {12'h000, cond_code[3:0]}, 16'h000B);
    $display("t_alu done");
  endtask
  task automatic t_wide();
    mv(3'h4, 16'h0012);
    mv(3'h5, 16'h3434);
    alu(cta_pkg::OP_UMUL, 4'hC, 4'hD, 16'h0000);
    ck(3'h4, 16'h03A8);
    mv(3'h4, 16'h03A9);
    alu(cta_pkg::OP_UDIV, 4'hC, 4'hD, 16'h0000);
    ck(3'h4, 16'h0112);
    alu(cta_pkg::OP_ADDR_ADD, 4'h4, 4'h0, 16'h0002);
    ck(3'h4, 16'h0114);
    alu(cta_pkg::OP_ADDR_SUB, 4'h4, 4'h0, 16'h0000);
    ck(3'h4, 16'h0113);
    mv(3'h6, 16'h0015);
    mv(3'h0, 16'h0027);
    alu(cta_pkg::OP_ADD, 4'hE, 4'h8, 16'h0000);
    alu(cta_pkg::OP_BCD_ADD, 4'hE, 4'h0, 16'h0000);
    ck(3'h6, 16'h0042);
    alu(cta_pkg::OP_SUB, 4'hE, 4'h8, 16'h0000);
    alu(cta_pkg::OP_BCD_SUB, 4'hE, 4'h0, 16'h0000);
    ck(3'h6, 16'h0015);
    alu(cta_pkg::OP_MOVE, 4'h4, 4'hE, 16'h0000);
    ck(3'h4, 16'h1513);
    $display("t_wide done");
  endtask
  // Stack, odd word address, pre-decrement and short absolute traffic
  task automatic t_mem();
    mv(3'h7, 16'h0100);
    mv(3'h1, 16'h12AB);
    run(cta_pkg::OP_PUSH, 1'b1, cta_pkg::MD_PREDEC, 1'b1, 4'h0, 4'h1, 3'h7, 16'h0000);
    ck(3'h7, 16'h00FE);
    run(cta_pkg::OP_POP, 1'b1, cta_pkg::MD_POSTINC, 1'b0, 4'h6, 4'h0, 3'h7, 16'h0000);
    ck(3'h6, 16'h12AB);
    ck(3'h7, 16'h0100);
    run(cta_pkg::OP_MOVE, 1'b1, cta_pkg::MD_ABS16, 1'b1, 4'h0, 4'h1, 3'h0, 16'h0301);
    mv(3'h3, 16'h0300);
    run(cta_pkg::OP_MOVE, 1'b1, cta_pkg::MD_IND, 1'b0, 4'h5, 4'h0, 3'h3, 16'h0000);
    ck(3'h5, 16'h12AB);
    mv(3'h3, 16'h0201);
    run(cta_pkg::OP_MOVE, 1'b0, cta_pkg::MD_PREDEC, 1'b1, 4'h0, 4'h9, 3'h3, 16'h0000);
    ck(3'h3, 16'h0200);
    run(cta_pkg::OP_MOVE, 1'b0, cta_pkg::MD_DISP, 1'b0, 4'h8, 4'h0, 3'h3, 16'h0000);
    ck(3'h0, 16'h00AB);
    run(cta_pkg::OP_MOVE, 1'b0, cta_pkg::MD_ABS8, 1'b1, 4'h0, 4'h9, 3'h0, 16'h0040);
    run(cta_pkg::OP_MOVE, 1'b0, cta_pkg::MD_ABS8, 1'b0, 4'h5, 4'h0, 3'h0, 16'h0040);
    ck(3'h5, 16'hABAB);
    $display("t_mem done");
  endtask
  // Missing forms are refused and change nothing
  task automatic t_ill();
    cta_pkg::cta_op_t ops [6] = '{cta_pkg::OP_SUB, cta_pkg::OP_ADD, cta_pkg::OP_ADD_CARRY,
      cta_pkg::OP_COMPARE, cta_pkg::OP_INC, cta_pkg::OP_MOVE};
    mv(3'h2, 16'h5A3C);
    foreach (ops[k]) begin
      run(ops[k], k != 0, (k == 5) ? cta_pkg::MD_ABS8 : cta_pkg::MD_IMM, 1'b0, 4'hA, 4'hB,
          3'h0, 16'h00FF);
      chk("refused", {15'h0, ill}, 16'h0001);
      ck(3'h2, 16'h5A3C);
    end
    $display("t_ill done");
  endtask
  initial begin
    repeat (20) @(posedge clock);
    sys_rst <= 1'b0;
    t_alu();
    t_wide();
    t_mem();
    t_ill();
    tally_and_finish();
  end
endmodule
